/* pkg/srp_pkg.sv */
// Purpose: constants for the session request controller
// Assumes: 200 MHz core clock, 32-bit register port
// Notes:
// How it works
// RL1 - a-role detection of a far request only when srp capable is set
// RL2 - software suspends and powers down the port while idle
// RL3 - transceiver drops bus power valid once port power is off
// RL4 - far device sees two ms of se0 before asking
// RL5 - far device pulses its data line pull-up for five to ten ms
// RL6 - a-role treats data line pulsing as a session request
// RL7 - requester pulses data line and bus power; acceptor needs either one
// RL8 - a detected request sets a sticky flag and raises the interrupt
// RL9 - software answers by turning port power on; valid then rises
// RL10 - b-role starts a request only when srp capable is set
// RL11 - three ms idle sets early suspend, then usb suspend
// RL12 - after suspend in b-role, ask the transceiver to discharge bus power
// RL13 - after session end, two ms of se0 before a request may start
// RL14 - software waits for bus discharge with a serial transceiver
// RL15 - discharge acceleration stays asserted until the request starts
// RL16 - software request bit starts data line pulsing, then bus power pulsing
// RL17 - bus power arriving sets the success change flag and success bit
// RL18 - powered bus after success makes the b-role connect
// RL19 - far device connects once powered, ending its request
package srp_pkg;
	localparam int unsigned CLK_KHZ      = 200000;
	localparam int unsigned IDLE_MS      = 3;
	localparam int unsigned SE0_MS       = 2;
	localparam int unsigned DLP_MS       = 5;
	localparam int unsigned VBP_MS       = 1;
	localparam int unsigned IDLE_CYC     = IDLE_MS * CLK_KHZ;
	localparam int unsigned SE0_CYC      = SE0_MS * CLK_KHZ;
	localparam int unsigned DLP_CYC      = DLP_MS * CLK_KHZ;
	localparam int unsigned VBP_CYC      = VBP_MS * CLK_KHZ;
	localparam int unsigned CNT_W        = 21;

	localparam logic [7:0] CFG_ADDR      = 8'h00;
	localparam logic [7:0] CTRL_ADDR     = 8'h04;
	localparam logic [7:0] STAT_ADDR     = 8'h08;
	localparam logic [7:0] ISTAT_ADDR    = 8'h0C;
	localparam logic [7:0] IMASK_ADDR    = 8'h10;

	localparam int unsigned CFG_SRP_CAP  = 0;
	localparam int unsigned CFG_A_ROLE   = 1;
	localparam int unsigned CTRL_SREQ    = 0;
	localparam int unsigned CTRL_PWR     = 1;
	localparam int unsigned INT_W        = 4;
	localparam int unsigned INT_SRQ      = 0;
	localparam int unsigned INT_ESUSP    = 1;
	localparam int unsigned INT_USUSP    = 2;
	localparam int unsigned INT_SUCC     = 3;
	localparam logic [INT_W-1:0] IMASK_RST = 4'h0;

	typedef enum logic [2:0] {B_IDLE, B_SUSP, B_SE0, B_READY, B_DLP, B_VBP, B_WAIT, B_CONN} bstate_e;
endpackage

/* core/otg_session_request_ctrl.sv */
// Purpose: session request logic of a dual-role usb port
// Assumes: all pins except rst_b synchronous to clk; single 200 MHz domain
// Notes: a-role detects far requests, b-role issues its own
`timescale 1ns/1ps
module otg_session_request_ctrl #(
	parameter int unsigned IDLE_CYC = srp_pkg::IDLE_CYC,
	parameter int unsigned SE0_CYC  = srp_pkg::SE0_CYC,
	parameter int unsigned DLP_CYC  = srp_pkg::DLP_CYC,
	parameter int unsigned VBP_CYC  = srp_pkg::VBP_CYC
) (
	input  wire logic        clk,                     // core clock
	input  wire logic        rst_b,                   // async reset, low
	input  wire logic [7:0]  addr,                    // register byte address
	input  wire logic [31:0] wdata,                   // write data
	input  wire logic        wr,                      // write strobe
	input  wire logic        rd,                      // read strobe
	output logic      [31:0] rdata,                   // read data, cycle after rd
	input  wire logic        bus_idle_in,             // bus shows no activity
	input  wire logic        line_se0,                // both data lines low
	input  wire logic        dp_line_high,            // d+ seen high
	input  wire logic        bus_power_valid_in,      // bus power valid
	input  wire logic        b_session_valid_status,  // b session valid
	input  wire logic        session_end_ind,         // session end
	output logic             vbus_drive_out,          // drive bus power (a-role)
	output logic             bus_power_discharge_req, // discharge request
	output logic             bus_power_charge_req,    // bus power pulsing
	output logic             dp_pullup_en,            // d+ pull-up
	output logic             irq                      // level interrupt
);
	logic                      srp_cap_reg;
	logic                      a_role_reg;
	logic                      sreq_reg;
	logic                      pwr_reg;
	logic                      succ_reg;
	logic [srp_pkg::INT_W-1:0] istat_reg;
	logic [srp_pkg::INT_W-1:0] imask_reg;
	logic [srp_pkg::INT_W-1:0] ev;
	logic [srp_pkg::CNT_W-1:0] idle_cnt_reg;
	logic [srp_pkg::CNT_W-1:0] cnt_reg;
	logic                      esusp_d_reg;
	logic                      susp_reg;
	logic                      dp_d_reg;
	logic                      bsv_d_reg;
	logic                      pv_d_reg;
	srp_pkg::bstate_e          st_reg;
	logic                      esusp_ev;
	logic                      srq_ev;
	logic                      succ_ev;
	logic                      in_req;
	logic                      sreq_wr;

	localparam logic [srp_pkg::CNT_W-1:0] idle_last = srp_pkg::CNT_W'(IDLE_CYC - 1);
	localparam logic [srp_pkg::CNT_W-1:0] se0_last  = srp_pkg::CNT_W'(SE0_CYC - 1);
	localparam logic [srp_pkg::CNT_W-1:0] dlp_last  = srp_pkg::CNT_W'(DLP_CYC - 1);
	localparam logic [srp_pkg::CNT_W-1:0] vbp_last  = srp_pkg::CNT_W'(VBP_CYC - 1);
	assign sreq_wr   = wr && addr == srp_pkg::CTRL_ADDR && wdata[srp_pkg::CTRL_SREQ];

	// register writes
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			srp_cap_reg <= 1'b0;
			a_role_reg  <= 1'b0;
			pwr_reg     <= 1'b0;
			imask_reg   <= srp_pkg::IMASK_RST;
		end
		else if (wr)
		begin
			if (addr == srp_pkg::CFG_ADDR)
			begin
				srp_cap_reg <= wdata[srp_pkg::CFG_SRP_CAP];
				a_role_reg  <= wdata[srp_pkg::CFG_A_ROLE];
			end
			else if (addr == srp_pkg::CTRL_ADDR)
				pwr_reg <= wdata[srp_pkg::CTRL_PWR];
			else if (addr == srp_pkg::IMASK_ADDR)
				imask_reg <= wdata[srp_pkg::INT_W-1:0];
		end
	end

	// request bit: software sets or clears, hardware clears when sequence ends
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			sreq_reg <= 1'b0;
		else if (wr && addr == srp_pkg::CTRL_ADDR)
			sreq_reg <= wdata[srp_pkg::CTRL_SREQ];
		else if (st_reg == srp_pkg::B_CONN)
			sreq_reg <= 1'b0;
	end

	// port power from software drives the bus in a-role
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			vbus_drive_out <= 1'b0;
		else
			vbus_drive_out <= pwr_reg && a_role_reg;
	end

	// edge history of link inputs
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dp_d_reg  <= 1'b0;
			bsv_d_reg <= 1'b0;
			pv_d_reg  <= 1'b0;
		end
		else
		begin
			dp_d_reg  <= dp_line_high;
			bsv_d_reg <= b_session_valid_status;
			pv_d_reg  <= bus_power_valid_in;
		end
	end

	// a-role: either pulse kind is enough while bus power is off
	assign srq_ev = srp_cap_reg && a_role_reg && !bus_power_valid_in &&                 // [RL1] [RL7]
		((dp_line_high && !dp_d_reg) || (b_session_valid_status && !bsv_d_reg));       // [RL6]

	// idle timer; saturates at the limit, and susp_reg makes early suspend fire once per idle stretch
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			idle_cnt_reg <= '0;
		else if (!bus_idle_in)
			idle_cnt_reg <= '0;
		else if (idle_cnt_reg != idle_last)
			idle_cnt_reg <= idle_cnt_reg + 1'b1;
	end

	assign esusp_ev = bus_idle_in && idle_cnt_reg == idle_last && !susp_reg;          // [RL11]
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			susp_reg    <= 1'b0;
			esusp_d_reg <= 1'b0;
		end
		else
		begin
			susp_reg    <= bus_idle_in && (susp_reg || esusp_ev);
			esusp_d_reg <= esusp_ev;                                                    // [RL11]
		end
	end

	assign in_req  = st_reg == srp_pkg::B_DLP || st_reg == srp_pkg::B_VBP || st_reg == srp_pkg::B_WAIT;
	assign succ_ev = in_req && !a_role_reg && bus_power_valid_in && !pv_d_reg;         // [RL17]
	// b-role sequence
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg  <= srp_pkg::B_IDLE;
			cnt_reg <= '0;
		end
		else if (a_role_reg)
		begin
			st_reg  <= srp_pkg::B_IDLE;
			cnt_reg <= '0;
		end
		else
		begin
			case (st_reg)
				srp_pkg::B_IDLE:
					if (esusp_d_reg)
						st_reg <= srp_pkg::B_SUSP;                                      // [RL12]
				srp_pkg::B_SUSP:
					if (session_end_ind)
					begin
						st_reg  <= srp_pkg::B_SE0;
						cnt_reg <= '0;
					end
				srp_pkg::B_SE0:
					if (!session_end_ind)
						st_reg <= srp_pkg::B_SUSP;
					else if (!line_se0)
						cnt_reg <= '0;                                                  // [RL13]
					else if (cnt_reg == se0_last)
						st_reg <= srp_pkg::B_READY;                                     // [RL13]
					else
						cnt_reg <= cnt_reg + 1'b1;
				srp_pkg::B_READY:
					if (sreq_reg && srp_cap_reg)
					begin
						st_reg  <= srp_pkg::B_DLP;                                      // [RL10] [RL16]
						cnt_reg <= '0;
					end
				srp_pkg::B_DLP:
					if (succ_ev)
						st_reg <= srp_pkg::B_CONN;
					else if (cnt_reg == dlp_last)
					begin
						st_reg  <= srp_pkg::B_VBP;                                      // [RL16]
						cnt_reg <= '0;
					end
					else
						cnt_reg <= cnt_reg + 1'b1;
				srp_pkg::B_VBP:
					if (succ_ev)
						st_reg <= srp_pkg::B_CONN;
					else if (cnt_reg == vbp_last)
						st_reg <= srp_pkg::B_WAIT;
					else
						cnt_reg <= cnt_reg + 1'b1;
				srp_pkg::B_WAIT:
					if (succ_ev)
						st_reg <= srp_pkg::B_CONN;                                      // [RL18]
					else if (!sreq_reg)
						st_reg <= srp_pkg::B_READY;
				srp_pkg::B_CONN:
					if (!bus_power_valid_in)
						st_reg <= srp_pkg::B_IDLE;
				default:
					st_reg <= srp_pkg::B_IDLE;
			endcase
		end
	end

	// pins follow state one cycle later, straight from flops
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bus_power_discharge_req <= 1'b0;
			bus_power_charge_req    <= 1'b0;
			dp_pullup_en            <= 1'b0;
		end
		else
		begin
			bus_power_discharge_req <= st_reg == srp_pkg::B_SUSP || st_reg == srp_pkg::B_SE0 ||  // [RL12]
				st_reg == srp_pkg::B_READY;                                             // [RL15]
			bus_power_charge_req    <= st_reg == srp_pkg::B_VBP;                       // [RL16]
			dp_pullup_en            <= st_reg == srp_pkg::B_DLP || st_reg == srp_pkg::B_CONN;  // [RL18]
		end
	end

	// success bit: set by bus power arrival, cleared by a new request
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			succ_reg <= 1'b0;
		else if (succ_ev)
			succ_reg <= 1'b1;                                                           // [RL17]
		else if (sreq_wr)
			succ_reg <= 1'b0;
	end

	always_comb
	begin
		ev                   = '0;
		ev[srp_pkg::INT_SRQ]   = srq_ev;                                                // [RL8]
		ev[srp_pkg::INT_ESUSP] = esusp_ev;
		ev[srp_pkg::INT_USUSP] = esusp_d_reg;
		ev[srp_pkg::INT_SUCC]  = succ_ev;
	end

	// sticky status; read clears, a same-cycle event survives
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			istat_reg <= '0;
		else if (rd && addr == srp_pkg::ISTAT_ADDR)
			istat_reg <= ev;
		else
			istat_reg <= istat_reg | ev;                                                // [RL8] [RL11]
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= |(istat_reg & imask_reg);                                            // [RL8]
	end

	// read port; unmapped addresses read zero
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata <= '0;
		else if (!rd)
			rdata <= '0;
		else if (addr == srp_pkg::CFG_ADDR)
			rdata <= {30'h0, a_role_reg, srp_cap_reg};
		else if (addr == srp_pkg::CTRL_ADDR)
			rdata <= {30'h0, pwr_reg, sreq_reg};
		else if (addr == srp_pkg::STAT_ADDR)
			rdata <= {24'h0, st_reg, susp_reg, session_end_ind, b_session_valid_status,
				bus_power_valid_in, succ_reg};
		else if (addr == srp_pkg::ISTAT_ADDR)
			rdata <= {28'h0, istat_reg};
		else if (addr == srp_pkg::IMASK_ADDR)
			rdata <= {28'h0, imask_reg};
		else
			rdata <= '0;
	end

	sequence dlp_run_s;
		st_reg == srp_pkg::B_DLP;
	endsequence
	sequence vbp_start_s;
		st_reg == srp_pkg::B_VBP && cnt_reg == '0;
	endsequence
	srq_gated_a: assert property (@(posedge clk) disable iff (!rst_b)   // [RL1]
		$rose(istat_reg[srp_pkg::INT_SRQ]) |-> $past(srp_cap_reg && a_role_reg))
		else $error("request flag set without srp capable a-role");
	dlp_detect_a: assert property (@(posedge clk) disable iff (!rst_b)  // [RL6]
		srp_cap_reg && a_role_reg && !bus_power_valid_in && dp_line_high && !dp_d_reg
		|=> istat_reg[srp_pkg::INT_SRQ])
		else $error("data line pulse not flagged");
	irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)   // [RL8]
		irq == $past(|(istat_reg & imask_reg)))
		else $error("interrupt level does not follow unmasked flags");
	b_start_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // [RL10]
		st_reg == srp_pkg::B_READY ##1 st_reg == srp_pkg::B_DLP |-> $past(srp_cap_reg && sreq_reg))
		else $error("request started without srp capable");
	usb_susp_a: assert property (@(posedge clk) disable iff (!rst_b)    // [RL11]
		esusp_ev |=> istat_reg[srp_pkg::INT_ESUSP] ##1 istat_reg[srp_pkg::INT_USUSP])
		else $error("suspend flags out of order");
	discharge_a: assert property (@(posedge clk) disable iff (!rst_b)   // [RL12]
		st_reg == srp_pkg::B_SUSP |=> bus_power_discharge_req)
		else $error("discharge not requested after suspend");
	se0_wait_a: assert property (@(posedge clk) disable iff (!rst_b)    // [RL13]
		st_reg == srp_pkg::B_SE0 ##1 st_reg == srp_pkg::B_READY |-> $past(cnt_reg) == se0_last)
		else $error("request ready before se0 time");
	dlp_order_a: assert property (@(posedge clk) disable iff (!rst_b)   // [RL16]
		dlp_run_s ##1 st_reg == srp_pkg::B_VBP |-> vbp_start_s ##1 bus_power_charge_req && !dp_pullup_en)
		else $error("bus power pulsing not after data line pulsing");
	success_a: assert property (@(posedge clk) disable iff (!rst_b)     // [RL17]
		succ_ev |=> succ_reg && istat_reg[srp_pkg::INT_SUCC])
		else $error("success not reported");
	connect_a: assert property (@(posedge clk) disable iff (!rst_b)     // [RL18]
		succ_ev |=> st_reg == srp_pkg::B_CONN ##1 dp_pullup_en)
		else $error("no connect after success");
endmodule // otg_session_request_ctrl

/* test/srp_partner.sv */
// Purpose: transceiver with far host or far device for the session request block
// Assumes: bench picks the role; pulse counts scaled down like the block's
// Notes: far host powers the bus HOST_DLY cycles after it first sees pulsing
`timescale 1ns/1ps
module srp_partner #(
	parameter int SE0      = 10,
	parameter int DLP      = 10,
	parameter int HOST_DLY = 12
) (
	input  wire logic clk,                     // core clock
	input  wire logic rst_b,                   // async reset, low
	input  wire logic a_side,                  // block is a-device
	input  wire logic suspend,                 // far host idles the bus
	input  wire logic go,                      // far device starts a request
	input  wire logic vbus_drive_out,          // block drives bus power
	input  wire logic bus_power_discharge_req, // discharge request
	input  wire logic bus_power_charge_req,    // bus power pulsing
	input  wire logic dp_pullup_en,            // block d+ pull-up
	output logic      bus_idle_in,             // no bus activity
	output logic      line_se0,                // both lines low
	output logic      dp_line_high,            // d+ high
	output logic      bus_power_valid_in,      // bus power valid
	output logic      b_session_valid_status,  // b session valid
	output logic      session_end_ind          // session end
);
	logic seen;
	logic sess;
	logic pwr;
	int   hcnt;
	int   t;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			seen <= 1'b0;
			sess <= 1'b0;
			hcnt <= 0;
			t    <= 0;
		end
		else
		begin
			if (dp_pullup_en || bus_power_charge_req)
				seen <= 1'b1;
			if (seen && hcnt != HOST_DLY)
				hcnt <= hcnt + 1;
			if (bus_power_discharge_req)
				sess <= 1'b1;
			else if (pwr)
				sess <= 1'b0;
			t <= go ? t + 1 : 0;
		end
	end
	// host powers up on either pulse kind
	assign pwr                    = (hcnt == HOST_DLY);
	assign bus_power_valid_in     = a_side ? vbus_drive_out : pwr;
	assign session_end_ind        = !a_side && sess;
	assign bus_idle_in            = !a_side && suspend && !pwr;
	// far device: se0, then d+ pulse, then bus power pulse
	assign line_se0               = a_side ? (t > 0 && t <= SE0) : (suspend && !dp_pullup_en && !pwr);
	assign dp_line_high           = a_side && ((t > SE0 && t <= SE0 + DLP) || vbus_drive_out);
	assign b_session_valid_status = a_side ? (t > SE0 + DLP && t <= SE0 + DLP + 4) : pwr;
endmodule // srp_partner

/* test/otg_session_request_ctrl_tb.sv */
// Purpose: self-checking bench for the session request block
// Assumes: scaled counts 20/10/10/5 cycles
// Notes: random mask values from an lfsr seeded at 45
`timescale 1ns/1ps
module otg_session_request_ctrl_tb;
	localparam int IDLE = 20;
	localparam int SE0  = 10;
	localparam int DLP  = 10;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        bus_idle_in, line_se0, dp_line_high, bus_power_valid_in, b_session_valid_status, session_end_ind;
	logic        vbus_drive_out, bus_power_discharge_req, bus_power_charge_req, dp_pullup_en, irq;
	logic        a_side = 1'b0;
	logic        suspend = 1'b0;
	logic        go = 1'b0;
	logic [7:0]  seed = 8'h2D;
	int          num_errors = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          n;

	otg_session_request_ctrl #(.IDLE_CYC(IDLE), .SE0_CYC(SE0), .DLP_CYC(DLP), .VBP_CYC(5)) DUT (
		.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.bus_idle_in(bus_idle_in), .line_se0(line_se0), .dp_line_high(dp_line_high),
		.bus_power_valid_in(bus_power_valid_in), .b_session_valid_status(b_session_valid_status),
		.session_end_ind(session_end_ind), .vbus_drive_out(vbus_drive_out),
		.bus_power_discharge_req(bus_power_discharge_req), .bus_power_charge_req(bus_power_charge_req),
		.dp_pullup_en(dp_pullup_en), .irq(irq));

	srp_partner #(.SE0(SE0), .DLP(DLP), .HOST_DLY(DLP + 2)) far_end (
		.clk(clk), .rst_b(rst_b), .a_side(a_side), .suspend(suspend), .go(go),
		.vbus_drive_out(vbus_drive_out), .bus_power_discharge_req(bus_power_discharge_req),
		.bus_power_charge_req(bus_power_charge_req), .dp_pullup_en(dp_pullup_en),
		.bus_idle_in(bus_idle_in), .line_se0(line_se0), .dp_line_high(dp_line_high),
		.bus_power_valid_in(bus_power_valid_in), .b_session_valid_status(b_session_valid_status),
		.session_end_ind(session_end_ind));

	always #2.5 clk = ~clk;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [4:0] outs();
		return {irq, dp_pullup_en, bus_power_charge_req, bus_power_discharge_req, vbus_drive_out};
	endfunction

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// rdata is only good in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, e, rdata & m);
	endtask

	// bounded wait on one output bit, sampled after the edge settles
	task automatic wait_hi(input int b, input int lim);
		logic [4:0] v;
		int         k;
		k = 0;
		#1;
		v = outs();
		while (v[b] !== 1'b1 && k < lim)
		begin
			@(posedge clk);
			#1;
			v = outs();
			k++;
		end
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			num_errors++;
			close_out();
		end
	end

	initial
	begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk("outs_rst", 32'h0, 32'(outs()));
		rd_chk(srp_pkg::CFG_ADDR, 32'hFFFFFFFF, 32'h0, "cfg_rst");
		rd_chk(srp_pkg::CTRL_ADDR, 32'hFFFFFFFF, 32'h0, "ctrl_rst");
		rd_chk(srp_pkg::IMASK_ADDR, 32'hFFFFFFFF, 32'h0, "imask_rst");
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			wr_reg(srp_pkg::IMASK_ADDR, {24'h0, seed});
			wr_reg(8'h40 | seed, 32'hFFFFFFFF);
			rd_chk(srp_pkg::IMASK_ADDR, 32'hFFFFFFFF, {28'h0, seed[3:0]}, "imask_rw");
			rd_chk(8'h80 | seed, 32'hFFFFFFFF, 32'h0, "unmapped");
		end
		wr_reg(srp_pkg::IMASK_ADDR, 32'hF);
		// a-role without capability: far pulsing goes unseen
		a_side <= 1'b1;
		wr_reg(srp_pkg::CFG_ADDR, 32'h2);
		go <= 1'b1;
		repeat (SE0 + DLP + 8) @(posedge clk);
		go <= 1'b0;
		rd_chk(srp_pkg::ISTAT_ADDR, 32'hF, 32'h0, "istat_nocap");
		wr_reg(srp_pkg::CFG_ADDR, 32'h3);
		go <= 1'b1;
		repeat (SE0 + DLP + 8) @(posedge clk);
		#1;
		chk("irq_srq", 32'h1, 32'(irq));
		rd_chk(srp_pkg::ISTAT_ADDR, 32'hF, 32'h1, "istat_srq");
		rd_chk(srp_pkg::ISTAT_ADDR, 32'hF, 32'h0, "istat_clr");
		chk("irq_clr", 32'h0, 32'(irq));
		wr_reg(srp_pkg::CTRL_ADDR, 32'h2);
		wait_hi(0, 4);
		chk("vbus_on", 32'h1, 32'(vbus_drive_out));
		wr_reg(srp_pkg::CTRL_ADDR, 32'h0);
		go <= 1'b0;
		// b-role: request parked while capability is off
		a_side <= 1'b0;
		wr_reg(srp_pkg::CFG_ADDR, 32'h0);
		wr_reg(srp_pkg::CTRL_ADDR, 32'h1);
		rd_chk(srp_pkg::ISTAT_ADDR, 32'hF, 32'h0, "istat_pre");
		@(posedge clk);
		suspend <= 1'b1;
		repeat (IDLE - 3) @(posedge clk);
		#1;
		chk("irq_early", 32'h0, 32'(irq));
		repeat (5) @(posedge clk);
		rd_chk(srp_pkg::ISTAT_ADDR, 32'hF, 32'h6, "istat_susp");
		wait_hi(1, 4);
		chk("disch", 32'h1, 32'(bus_power_discharge_req));
		// software lets bus power discharge after session end before enabling the request
		repeat (SE0 + 20) @(posedge clk);
		#1;
		chk("dp_nocap", 32'h0, 32'(dp_pullup_en));
		chk("disch_hold", 32'h1, 32'(bus_power_discharge_req));
		wr_reg(srp_pkg::CFG_ADDR, 32'h1);
		wait_hi(3, 6);
		chk("disch_off", 32'h0, 32'(bus_power_discharge_req));
		n = 0;
		while (dp_pullup_en === 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("dlp_len", DLP, n);
		chk("chrg", 32'h1, 32'(bus_power_charge_req));
		wait_hi(3, 12);
		chk("connect", 32'h1, 32'(dp_pullup_en));
		chk("chrg_off", 32'h0, 32'(bus_power_charge_req));
		rd_chk(srp_pkg::ISTAT_ADDR, 32'hF, 32'h8, "istat_succ");
		rd_chk(srp_pkg::STAT_ADDR, 32'h1, 32'h1, "stat_succ");
		rd_chk(srp_pkg::CTRL_ADDR, 32'h1, 32'h0, "sreq_clr");
		close_out();
	end
endmodule // otg_session_request_ctrl_tb
